// ==== bac_map.svh ====
`ifndef BAC_MAP_SVH
`define BAC_MAP_SVH

// address, counter, mask and mirror width
`define BAC_AW 18
// counter value after master reset
`define BAC_CNT_RST 18'h00000
// mask value after master reset or mask reset
`define BAC_MSK_ONES 18'h3ffff
// mirror value after master reset
`define BAC_MIR_RST 18'h00000
// wrap flag idle (deasserted) level
`define BAC_WRAP_IDLE 1'b1
// readback output value after reset
`define BAC_RB_RST 18'h00000

`endif

// ==== bac_pkg.sv ====
`default_nettype none
`include "bac_map.svh"

package bac_pkg;

   typedef logic [`BAC_AW-1:0] bac_addr_t;

   // decoded counter operation, one-hot
   typedef enum logic [8:0] {
      BAC_OP_CCLR = 9'h001,
      BAC_OP_CLD  = 9'h002,
      BAC_OP_CRD  = 9'h004,
      BAC_OP_CINC = 9'h008,
      BAC_OP_HOLD = 9'h010,
      BAC_OP_MCLR = 9'h020,
      BAC_OP_MLD  = 9'h040,
      BAC_OP_MRD  = 9'h080,
      BAC_OP_RSVD = 9'h100
   } bac_op_e;

   // true when every unmasked bit of the value is one
   function automatic logic bac_unmasked_ones(input bac_addr_t v,
                                              input bac_addr_t m);
      bac_unmasked_ones = &(v | ~m);
   endfunction

endpackage

`default_nettype wire

// ==== bac_cnt_if.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bac_map.svh"

interface bac_cnt_if;
   logic [`BAC_AW-1:0] cnt;
   logic [`BAC_AW-1:0] mask;
   logic [`BAC_AW-1:0] mirror;
   logic [`BAC_AW-1:0] nxt;
   logic nxt_wrap_n;

   modport core (output cnt, output mask, output mirror,
                 input nxt, input nxt_wrap_n);
   modport calc (input cnt, input mask, input mirror,
                 output nxt, output nxt_wrap_n);
endinterface

`default_nettype wire

// ==== bac_incr.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bac_map.svh"

module bac_incr
   import bac_pkg::*;
(
   // counter state in, next value out
   bac_cnt_if.calc cif
);

   wire logic at_top;
   wire bac_addr_t filled;
   wire bac_addr_t summed;
   wire bac_addr_t stepped;

   assign at_top = bac_unmasked_ones(cif.cnt, cif.mask);

   assign filled = cif.cnt | ~cif.mask;
   assign summed = bac_addr_t'(filled + bac_addr_t'(1));

   assign stepped = (summed & cif.mask) | (cif.cnt & ~cif.mask);

   assign cif.nxt = at_top ? cif.mirror : stepped;

   assign cif.nxt_wrap_n = ~bac_unmasked_ones(cif.nxt, cif.mask);

endmodule

`default_nettype wire

// ==== bac_burst_counter.sv ====
// Operation
// - master reset clears counter to zeros and sets mask to all ones.
// - counter reset clears unmasked counter bits only, masked bits kept.
// - counter select, strobe and enable low load counter from address.
// - counter select, strobe low, enable high reads counter onto address.
// - counter select, strobe high, enable low increments counter each edge.
// - all controls high hold counter, mask and mirror unchanged.
// - mask select with clear low sets every mask bit to one.
// - mask select, strobe and enable low load mask from address.
// - mask select, strobe low, enable high reads mask onto address.
// - counter readback valid after next edge; data floats if enabled.
// - mask readback valid after next edge; data floats if enabled.
// - wrap flag low when increment leaves unmasked bits all ones.
// - wrap flag high on counter or mask reset or load, master reset.
// - counter and mask operations ignore both chip enables.
// - increment past unmasked maximum reloads counter from mirror.
// - cleared mask bit zero makes counter step by two.
// - counter load writes address into counter and mirror.
// - counter reset copies resulting counter value into mirror.
// - increment changes only unmasked counter bits.
// - master reset asynchronous; other controls sampled on rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "bac_map.svh"

module bac_burst_counter
   import bac_pkg::*;
(
   // clock and resets
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic master_reset_n,
   // counter controls
   input wire logic counter_or_mask_select,
   input wire logic counter_clear_n,
   input wire logic address_strobe_n,
   input wire logic count_enable_n,
   // chip enables
   input wire logic chip_select_low_active,
   input wire logic chip_select_high_active,
   // address pins
   input wire logic [`BAC_AW-1:0] addr_in,
   output logic [`BAC_AW-1:0] addr_out,
   output logic addr_oe,
   // towards the array and data pins
   output logic [`BAC_AW-1:0] mem_addr,
   output logic dq_float,
   // wrap flag
   output logic wrap_flag_n
);

   bac_addr_t cnt_q;
   bac_addr_t cnt_d;
   bac_addr_t mask_q;
   bac_addr_t mask_d;
   bac_addr_t mirror_q;
   bac_addr_t mirror_d;
   bac_addr_t rb_q;
   bac_addr_t rb_d;
   logic rb_oe_q;
   logic rb_oe_d;
   logic float_q;
   logic float_d;
   logic wrap_q;
   logic wrap_d;

   bac_op_e op;
   wire logic is_cclr;
   wire logic is_cld;
   wire logic is_crd;
   wire logic is_cinc;
   wire logic is_hold;
   wire logic is_mclr;
   wire logic is_mld;
   wire logic is_mrd;
   wire logic is_rsvd;
   wire logic port_on;
   wire bac_addr_t cleared;

   bac_cnt_if cif ();

   assign cif.cnt = cnt_q;
   assign cif.mask = mask_q;
   assign cif.mirror = mirror_q;

   bac_incr u_incr (
      .cif (cif)
   );

   assign op = !counter_clear_n ?
                  (counter_or_mask_select ? BAC_OP_CCLR : BAC_OP_MCLR) :
               !address_strobe_n ?
                  (!count_enable_n ?
                     (counter_or_mask_select ? BAC_OP_CLD : BAC_OP_MLD) :
                     (counter_or_mask_select ? BAC_OP_CRD : BAC_OP_MRD)) :
               counter_or_mask_select ?
                  (!count_enable_n ? BAC_OP_CINC : BAC_OP_HOLD) :
               BAC_OP_RSVD;

   assign is_cclr = (op == BAC_OP_CCLR);
   assign is_cld = (op == BAC_OP_CLD);
   assign is_crd = (op == BAC_OP_CRD);
   assign is_cinc = (op == BAC_OP_CINC);
   assign is_hold = (op == BAC_OP_HOLD);
   assign is_mclr = (op == BAC_OP_MCLR);
   assign is_mld = (op == BAC_OP_MLD);
   assign is_mrd = (op == BAC_OP_MRD);
   assign is_rsvd = (op == BAC_OP_RSVD);

   assign port_on = !chip_select_low_active && chip_select_high_active;

   assign cleared = cnt_q & ~mask_q;

   assign cnt_d = is_cclr ? cleared :
                  is_cld ? addr_in :
                  is_cinc ? cif.nxt :
                  cnt_q;

   assign mirror_d = is_cclr ? cleared :
                     is_cld ? addr_in :
                     mirror_q;

   assign mask_d = is_mclr ? `BAC_MSK_ONES :
                   is_mld ? addr_in :
                   mask_q;

   // flag on increment, deassert on loads
   assign wrap_d = is_cinc ? cif.nxt_wrap_n :
                   (is_cclr || is_cld || is_mclr || is_mld) ?
                      `BAC_WRAP_IDLE :
                   wrap_q;

   assign rb_d = is_crd ? cnt_q :
                 is_mrd ? mask_q :
                 rb_q;
   assign rb_oe_d = is_crd || is_mrd;

   assign float_d = (is_crd || is_mrd) && port_on;

   always_ff @(posedge sys_clk or negedge master_reset_n) begin
      if (!master_reset_n) begin
         cnt_q <= `BAC_CNT_RST;
         mask_q <= `BAC_MSK_ONES;
         mirror_q <= `BAC_MIR_RST;
      end else if (!rst_b) begin
         cnt_q <= `BAC_CNT_RST;
         mask_q <= `BAC_MSK_ONES;
         mirror_q <= `BAC_MIR_RST;
      end else begin
         cnt_q <= cnt_d;
         mask_q <= mask_d;
         mirror_q <= mirror_d;
      end
   end

   always_ff @(posedge sys_clk or negedge master_reset_n) begin
      if (!master_reset_n) begin
         wrap_q <= `BAC_WRAP_IDLE;
      end else if (!rst_b) begin
         wrap_q <= `BAC_WRAP_IDLE;
      end else begin
         wrap_q <= wrap_d;
      end
   end

   always_ff @(posedge sys_clk or negedge master_reset_n) begin
      if (!master_reset_n) begin
         rb_q <= `BAC_RB_RST;
         rb_oe_q <= 1'b0;
         float_q <= 1'b0;
      end else if (!rst_b) begin
         rb_q <= `BAC_RB_RST;
         rb_oe_q <= 1'b0;
         float_q <= 1'b0;
      end else begin
         rb_q <= rb_d;
         rb_oe_q <= rb_oe_d;
         float_q <= float_d;
      end
   end

   assign addr_out = rb_q;
   assign addr_oe = rb_oe_q;
   assign dq_float = float_q;
   assign wrap_flag_n = wrap_q;
   assign mem_addr = cnt_q;

   // checks on the counter path

   property p_mreset;
      @(posedge sys_clk)
      !master_reset_n |-> cnt_q == `BAC_CNT_RST && mask_q == `BAC_MSK_ONES
                          && wrap_flag_n;
   endproperty
   a_mreset: assert property (p_mreset)
      else $error("master reset did not clear counter and mask");

   property p_cclr;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      is_cclr |=> cnt_q == ($past(cnt_q) & ~$past(mask_q))
                  && mirror_q == cnt_q;
   endproperty
   a_cclr: assert property (p_cclr)
      else $error("counter reset result wrong");

   property p_cld;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      is_cld |=> cnt_q == $past(addr_in) && mirror_q == $past(addr_in);
   endproperty
   a_cld: assert property (p_cld)
      else $error("counter load did not take address");

   property p_crd;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      is_crd |=> addr_oe && addr_out == $past(cnt_q)
                 && dq_float == $past(port_on);
   endproperty
   a_crd: assert property (p_crd)
      else $error("counter readback wrong");

   property p_cinc;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      is_cinc && !bac_unmasked_ones(cnt_q, mask_q) |=>
         (cnt_q & ~mask_q) == ($past(cnt_q) & ~$past(mask_q))
         && cnt_q != $past(cnt_q);
   endproperty
   a_cinc: assert property (p_cinc)
      else $error("increment touched masked bits");

   property p_step;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      is_cinc && mask_q[0] && !bac_unmasked_ones(cnt_q, mask_q)
         && !cnt_q[0] |=> cnt_q == ($past(cnt_q) | 18'h00001);
   endproperty
   a_step: assert property (p_step)
      else $error("increment by one wrong");

   property p_hold;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      is_hold ##1 is_hold |=> $stable(cnt_q) && $stable(mask_q)
                              && $stable(mirror_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("hold changed a register");

   property p_mclr;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      is_mclr |=> mask_q == `BAC_MSK_ONES && wrap_flag_n;
   endproperty
   a_mclr: assert property (p_mclr)
      else $error("mask reset did not set ones");

   property p_mld;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      is_mld |=> mask_q == $past(addr_in) && $stable(cnt_q);
   endproperty
   a_mld: assert property (p_mld)
      else $error("mask load wrong");

   property p_mrd;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      is_mrd |=> addr_oe && addr_out == $past(mask_q)
                 && dq_float == $past(port_on);
   endproperty
   a_mrd: assert property (p_mrd)
      else $error("mask readback wrong");

   property p_wrap_low;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      is_cinc |=> wrap_flag_n == !bac_unmasked_ones(cnt_q, mask_q);
   endproperty
   a_wrap_low: assert property (p_wrap_low)
      else $error("wrap flag disagrees with counter");

   property p_wrap_clr;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      (is_cclr || is_cld || is_mclr || is_mld) |=> wrap_flag_n;
   endproperty
   a_wrap_clr: assert property (p_wrap_clr)
      else $error("wrap flag not deasserted");

   property p_retx;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      is_cinc && bac_unmasked_ones(cnt_q, mask_q) |=>
         cnt_q == $past(mirror_q) && $stable(mirror_q);
   endproperty
   a_retx: assert property (p_retx)
      else $error("wrap did not reload mirror");

   property p_by_two;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      is_cinc && !mask_q[0] |=> cnt_q[0] == $past(cnt_q[0]);
   endproperty
   a_by_two: assert property (p_by_two)
      else $error("masked lsb changed on increment");

   property p_rsvd;
      @(posedge sys_clk) disable iff (!master_reset_n || !rst_b)
      is_rsvd |=> $stable(cnt_q) && $stable(mask_q) && $stable(mirror_q)
                  && !addr_oe && !dq_float;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved code had an effect");

endmodule

`default_nettype wire

// ==== bac_master.sv ====
`timescale 1ns/1ps
`default_nettype none

module bac_master
   import bac_pkg::*;
(
   // clock and requests
   input wire logic sys_clk,
   input wire logic master_reset_n_req,
   input wire logic drv_en,
   input wire bac_addr_t drv_val,
   // device address pins
   input wire bac_addr_t addr_out,
   input wire logic addr_oe,
   output bac_addr_t addr_in,
   // master reset
   output logic master_reset_n
);
   logic [2:0] pwr_q = 3'h5;
   bac_addr_t last_q = 18'h00000;

   always_ff @(posedge sys_clk) begin
      if (pwr_q != 3'h0) begin
         pwr_q <= pwr_q - 3'h1;
      end
   end
   // high until the first rising edge at power up, then a clean falling edge into reset
   assign master_reset_n = !master_reset_n_req && (pwr_q == 3'h0 || pwr_q == 3'h5);

   assign addr_in = addr_oe ? addr_out : (drv_en ? drv_val : ~last_q);
   always_ff @(posedge sys_clk) begin
      last_q <= addr_in;
   end
endmodule

`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench
   import bac_pkg::*;
;
   localparam logic [3:0] C_LD = 4'hc, C_RD = 4'hd, C_INC = 4'he;
   localparam logic [3:0] C_HLD = 4'hf, C_CLR = 4'hb, M_CLR = 4'h3;
   localparam logic [3:0] M_LD = 4'h4, M_RD = 4'h5, RSV = 4'h7;
   logic sys_clk = 1'b0, rst_b = 1'b0, master_reset_n_req = 1'b0, drv_en = 1'b0;
   logic [3:0] ctl = 4'hf;
   logic cs_l = 1'b0, cs_h = 1'b1;
   bac_addr_t drv_val = 18'h00000, addr_in, addr_out, mem_addr;
   logic master_reset_n, addr_oe, dq_float, wrap_flag_n;
   int err_count = 0, compares = 0;

   always #2.5 sys_clk = ~sys_clk;

   bac_master PM (.sys_clk(sys_clk), .master_reset_n_req(master_reset_n_req), .drv_en(drv_en),
      .drv_val(drv_val), .addr_out(addr_out), .addr_oe(addr_oe),
      .addr_in(addr_in), .master_reset_n(master_reset_n));
   bac_burst_counter DUT (.sys_clk(sys_clk), .rst_b(rst_b),
      .master_reset_n(master_reset_n), .counter_or_mask_select(ctl[3]),
      .counter_clear_n(ctl[2]), .address_strobe_n(ctl[1]),
      .count_enable_n(ctl[0]), .chip_select_low_active(cs_l),
      .chip_select_high_active(cs_h), .addr_in(addr_in),
      .addr_out(addr_out), .addr_oe(addr_oe), .mem_addr(mem_addr),
      .dq_float(dq_float), .wrap_flag_n(wrap_flag_n));

   task automatic give_verdict();
      $display("compares %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk_a(input bac_addr_t got, input bac_addr_t exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_b(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask

   // present one op at a falling edge, return at the next falling edge
   task automatic step(input logic [3:0] c, input bac_addr_t v);
      ctl = c;
      drv_val = v;
      drv_en = (c[1:0] == 2'b00) && c[2];
      @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic rd(input logic [3:0] c, input bac_addr_t e, input logic fl);
      step(c, 18'h00000);
      chk_a(addr_out, e);
      chk_b(addr_oe, 1'b1);
      chk_b(dq_float, fl);
      step(C_HLD, 18'h00000);
      chk_b(addr_oe, 1'b0);
   endtask

   task automatic t_reset();
      chk_a(mem_addr, 18'h00000);
      chk_b(wrap_flag_n, 1'b1);
      rd(M_RD, 18'h3ffff, 1'b1);
      rd(C_RD, 18'h00000, 1'b1);
   endtask

   task automatic t_wrap();
      step(M_LD, 18'h0003f); // legal mask
      step(C_LD, 18'h00108);
      chk_a(mem_addr, 18'h00108);
      for (int i = 9; i <= 63; i++) begin
         step(C_INC, 18'h00000);
         chk_a(mem_addr, 18'h00100 | 18'(i));
         chk_b(wrap_flag_n, i != 63);
      end
      step(C_INC, 18'h00000);
      chk_a(mem_addr, 18'h00108);
      chk_b(wrap_flag_n, 1'b1);
   endtask

   task automatic t_by2();
      step(M_LD, 18'h3fffe); // legal mask
      step(C_LD, 18'h00004);
      step(C_INC, 18'h00000);
      chk_a(mem_addr, 18'h00006);
      step(C_INC, 18'h00000);
      chk_a(mem_addr, 18'h00008);
   endtask

   task automatic t_clr();
      step(M_LD, 18'h00003);
      step(C_LD, 18'h12346);
      step(C_INC, 18'h00000);
      chk_b(wrap_flag_n, 1'b0);
      step(C_CLR, 18'h00000);
      chk_a(mem_addr, 18'h12344);
      chk_b(wrap_flag_n, 1'b1);
      repeat (3) step(C_INC, 18'h00000);
      chk_a(mem_addr, 18'h12347);
      step(C_INC, 18'h00000);
      chk_a(mem_addr, 18'h12344);
   endtask

   task automatic t_rdback();
      rd(C_RD, 18'h12344, 1'b1);
      cs_l = 1'b1;
      step(C_LD, 18'h3ffaa);
      chk_a(mem_addr, 18'h3ffaa);
      rd(C_RD, 18'h3ffaa, 1'b0);
      cs_h = 1'b0;
      rd(M_RD, 18'h00003, 1'b0);
      cs_l = 1'b0;
      cs_h = 1'b1;
   endtask

   task automatic t_hold_rsv();
      repeat (5) step(C_HLD, 18'h00000);
      chk_a(mem_addr, 18'h3ffaa);
      step(RSV, 18'h00000);
      chk_b(addr_oe, 1'b0);
      chk_a(mem_addr, 18'h3ffaa);
      rd(M_RD, 18'h00003, 1'b1);
   endtask

   task automatic t_mclr();
      step(C_INC, 18'h00000);
      chk_b(wrap_flag_n, 1'b0);
      step(M_CLR, 18'h00000);
      chk_b(wrap_flag_n, 1'b1);
      rd(M_RD, 18'h3ffff, 1'b1);
   endtask

   task automatic t_master_reset_n();
      step(M_LD, 18'h000ff);
      step(C_LD, 18'h000fe);
      step(C_INC, 18'h00000);
      chk_b(wrap_flag_n, 1'b0);
      master_reset_n_req = 1'b1;
      #1;
      chk_a(mem_addr, 18'h00000);
      chk_b(wrap_flag_n, 1'b1);
      @(negedge sys_clk);
      master_reset_n_req = 1'b0;
      rd(M_RD, 18'h3ffff, 1'b1);
   endtask

   initial begin
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_b = 1'b1;
      t_reset();
      t_wrap();
      t_by2();
      t_clr();
      t_rdback();
      t_hold_rsv();
      t_mclr();
      t_master_reset_n();
      give_verdict();
   end

   initial begin
      #20000;
      err_count++;
      give_verdict();
   end
endmodule

`default_nettype wire
